// >>> hdl/cam_pkg.sv
// Constants and types shared by the arithmetic, multiply and divide unit
package cam_pkg;
	localparam int CAM_W = 16;
	localparam int CAM_BYTE_W = 8;
	localparam int CAM_LIT_W = 5;
	// Divide iterates once per divisor bit
	localparam int DIV_CYCLES = CAM_W;
	// Status word bit positions
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_N = 2;
	localparam int ST_OV = 3;
	localparam int ST_DC = 4;
	localparam int ST_W = 5;
	localparam logic [ST_W-1:0] STATUS_RESET = 5'h00;
	localparam logic [CAM_W-1:0] WORD_RESET = 16'h0000;
	typedef enum logic [3:0] {
		OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR, OP_ASR,
		OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US, OP_MUL_SLIT, OP_MUL_ULIT, OP_MUL_BYTE
	} cam_op_e;
	typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_FIX} cam_div_state_e;
endpackage

// >>> hdl/cam_alu_mul_div.sv
// Integer arithmetic unit with multiplier and iterative divider
`timescale 1ns/1ps
`default_nettype none

// Function
// - 16-bit datapath adds, subtracts, shifts and does logic operations
// - Arithmetic operands and results are two's complement unless stated otherwise
// - Add and subtract update carry, zero, negative, signed wrap and nibble flags
// - Shifts update carry, zero and negative; logic ops zero and negative; multiplies leave all flags
// - Subtract uses carry and nibble flags as inverted borrow indicators
// - Byte or word width per instruction; flags evaluated at that width
// - Operands from register file or memory; result to either destination
// - 17x17 multiplier gives signed, unsigned and mixed-sign 16x16 products
// - Register operand times unsigned 5-bit literal, signed or unsigned
// - Byte mode multiplies two unsigned 8-bit operands
// - Divide 32/16 and 16/16, each signed and unsigned
// - Quotient always to quotient_reg, remainder always to remainder_reg
// - Divisor any register; 32-bit dividend from aligned pair, odd is upper
// - One cycle per divisor bit; both divide sizes take equal cycles
module cam_alu_mul_div
	import cam_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Operation request
	input wire logic op_valid_in,
	input wire cam_op_e op_code_in,
	input wire logic byte_mode_in,
	input wire logic [CAM_LIT_W-1:0] literal_in,
	// Operand sources
	input wire logic a_from_mem_in,
	input wire logic b_from_mem_in,
	input wire logic [CAM_W-1:0] a_file_in,
	input wire logic [CAM_W-1:0] a_mem_in,
	input wire logic [CAM_W-1:0] b_file_in,
	input wire logic [CAM_W-1:0] b_mem_in,
	input wire logic dest_mem_in,
	// Divide request
	input wire logic div_start_in,
	input wire logic div_signed_in,
	input wire logic div_long_in,
	input wire logic [CAM_W-1:0] dividend_even_in,
	input wire logic [CAM_W-1:0] dividend_odd_in,
	input wire logic [CAM_W-1:0] divisor_in,
	// Results
	output logic result_valid_out,
	output logic result_to_mem_out,
	output logic [CAM_W-1:0] result_out,
	output logic [CAM_W-1:0] result_hi_out,
	output logic [ST_W-1:0] status_word_out,
	// Divide results
	output logic div_busy_out,
	output logic div_done_out,
	output logic [CAM_W-1:0] quotient_reg_out,
	output logic [CAM_W-1:0] remainder_reg_out
);
	// ------------------------------------------------------------
	// Operand steering and adder
	// ------------------------------------------------------------
	wire [CAM_W-1:0] op_a = a_from_mem_in ? a_mem_in : a_file_in;
	wire [CAM_W-1:0] op_b = b_from_mem_in ? b_mem_in : b_file_in;
	wire is_sub = (op_code_in == OP_SUB);
	// Subtract as a + ~b + 1, so carry out means no borrow
	wire [CAM_W-1:0] b_eff = is_sub ? ~op_b : op_b;
	wire [CAM_W:0] sum_w = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, is_sub};
	wire [CAM_BYTE_W:0] sum_b = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, is_sub};
	wire [4:0] sum_nib = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};
	wire a_msb = byte_mode_in ? op_a[7] : op_a[15];
	wire b_msb = byte_mode_in ? b_eff[7] : b_eff[15];
	wire add_c = byte_mode_in ? sum_b[8] : sum_w[16];
	wire sr_in = (op_code_in == OP_ASR) ? a_msb : 1'b0;
	wire [CAM_W-1:0] shr = byte_mode_in ? {8'h00, sr_in, op_a[7:1]} : {sr_in, op_a[15:1]};

	// ------------------------------------------------------------
	// Operation select and width merge
	// ------------------------------------------------------------
	logic [CAM_W-1:0] raw_res;
	logic op_c;
	// Shift out bit feeds carry; logic ops leave carry alone
	always_comb begin
		raw_res = sum_w[CAM_W-1:0];
		op_c = add_c;
		case (op_code_in)
			OP_AND: raw_res = op_a & op_b;
			OP_IOR: raw_res = op_a | op_b;
			OP_XOR: raw_res = op_a ^ op_b;
			OP_SHL: begin
				raw_res = {op_a[14:0], 1'b0};
				op_c = a_msb;
			end
			OP_LSR, OP_ASR: begin
				raw_res = shr;
				op_c = op_a[0];
			end
			default: begin
				raw_res = sum_w[CAM_W-1:0];
				op_c = add_c;
			end
		endcase
	end
	// Byte ops keep the upper byte of the first operand intact
	wire [CAM_W-1:0] alu_res = byte_mode_in ? {op_a[15:8], raw_res[7:0]} : raw_res;
	wire res_msb = byte_mode_in ? alu_res[7] : alu_res[15];
	wire res_zero = byte_mode_in ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
	wire is_arith = (op_code_in == OP_ADD) || is_sub;
	wire is_shift = (op_code_in == OP_SHL) || (op_code_in == OP_LSR) || (op_code_in == OP_ASR);
	wire is_mul = (op_code_in >= OP_MUL_SS);
	wire arith_ov = (a_msb == b_msb) && (res_msb != a_msb);

	// ------------------------------------------------------------
	// Status word update per operation class
	// ------------------------------------------------------------
	logic [ST_W-1:0] next_status;
	always_comb begin
		next_status = status_word_out;
		if (op_valid_in && !is_mul) begin
			next_status[ST_Z] = res_zero;
			next_status[ST_N] = res_msb;
			if (is_arith || is_shift)
				next_status[ST_C] = op_c;
			if (is_arith) begin
				next_status[ST_OV] = arith_ov;
				next_status[ST_DC] = sum_nib[4];
			end
		end
	end

	// ------------------------------------------------------------
	// Multiplier, 17x17 signed core
	// ------------------------------------------------------------
	// The extra bit carries sign or zero so one signed array covers all modes
	wire a_sx = ((op_code_in == OP_MUL_SS) || (op_code_in == OP_MUL_SU) ||
		(op_code_in == OP_MUL_SLIT)) && op_a[15];
	wire b_sx = ((op_code_in == OP_MUL_SS) || (op_code_in == OP_MUL_US)) && op_b[15];
	wire is_lit = (op_code_in == OP_MUL_SLIT) || (op_code_in == OP_MUL_ULIT);
	wire is_mb = (op_code_in == OP_MUL_BYTE);
	wire [CAM_W:0] mul_a = is_mb ? {9'h000, op_a[7:0]} : {a_sx, op_a};
	wire [CAM_W:0] mul_b = is_lit ? {12'h000, literal_in} :
		(is_mb ? {9'h000, op_b[7:0]} : {b_sx, op_b});
	wire signed [2*CAM_W+1:0] mul_p = $signed(mul_a) * $signed(mul_b);

	// ------------------------------------------------------------
	// Result and status registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			result_valid_out <= 1'b0;
			result_to_mem_out <= 1'b0;
			result_out <= WORD_RESET;
			result_hi_out <= WORD_RESET;
			status_word_out <= STATUS_RESET;
		end else begin
			result_valid_out <= op_valid_in;
			status_word_out <= next_status;
			if (op_valid_in) begin
				result_to_mem_out <= dest_mem_in;
				result_out <= is_mul ? mul_p[CAM_W-1:0] : alu_res;
				result_hi_out <= is_mul ? mul_p[2*CAM_W-1:CAM_W] : WORD_RESET;
			end
		end
	end

	// ------------------------------------------------------------
	// Divider: operand magnitudes
	// ------------------------------------------------------------
	// Short divides see a 32-bit dividend whose upper half is the extension
	wire [2*CAM_W-1:0] dd_raw = div_long_in ? {dividend_odd_in, dividend_even_in} :
		{{CAM_W{div_signed_in & dividend_even_in[15]}}, dividend_even_in};
	wire dd_neg = div_signed_in & dd_raw[31];
	wire dv_neg = div_signed_in & divisor_in[15];
	wire [2*CAM_W-1:0] dd_mag = dd_neg ? (~dd_raw + 32'h00000001) : dd_raw;
	wire [CAM_W-1:0] dv_mag = dv_neg ? (~divisor_in + 16'h0001) : divisor_in;

	cam_div_state_e div_state;
	logic [4:0] div_cnt;
	logic [CAM_W-1:0] rem_acc, quo_acc, dv_hold;
	logic q_neg, r_neg;
	// One restoring step: shift in next dividend bit, subtract if it fits
	wire [CAM_W+1:0] trial = {1'b0, rem_acc, quo_acc[15]} - {2'b00, dv_hold};
	wire fits = ~trial[CAM_W+1];
	wire [CAM_W-1:0] next_rem = fits ? trial[CAM_W-1:0] : {rem_acc[14:0], quo_acc[15]};
	wire [CAM_W-1:0] next_quo = {quo_acc[14:0], fits};
	assign div_busy_out = (div_state != DV_IDLE);

	// ------------------------------------------------------------
	// Divider sequencer
	// ------------------------------------------------------------
	// Overflowing quotients are not flagged and come out wrong, not truncated; software must check range
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			div_state <= DV_IDLE;
			div_cnt <= 5'h00;
			rem_acc <= WORD_RESET;
			quo_acc <= WORD_RESET;
			dv_hold <= WORD_RESET;
			q_neg <= 1'b0;
			r_neg <= 1'b0;
			div_done_out <= 1'b0;
			quotient_reg_out <= WORD_RESET;
			remainder_reg_out <= WORD_RESET;
		end else begin
			div_done_out <= 1'b0;
			case (div_state)
				DV_IDLE: if (div_start_in) begin
					rem_acc <= dd_mag[31:16];
					quo_acc <= dd_mag[15:0];
					dv_hold <= dv_mag;
					q_neg <= dd_neg ^ dv_neg;
					r_neg <= dd_neg;
					div_cnt <= 5'h00;
					div_state <= DV_RUN;
				end
				DV_RUN: begin
					rem_acc <= next_rem;
					quo_acc <= next_quo;
					div_cnt <= div_cnt + 5'h01;
					if (div_cnt == 5'(DIV_CYCLES - 1))
						div_state <= DV_FIX;
				end
				DV_FIX: begin
					quotient_reg_out <= q_neg ? (~quo_acc + 16'h0001) : quo_acc;
					remainder_reg_out <= r_neg ? (~rem_acc + 16'h0001) : rem_acc;
					div_done_out <= 1'b1;
					div_state <= DV_IDLE;
				end
				default: div_state <= DV_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	logic [CAM_W-1:0] chk_dd, chk_dv;
	logic chk_plain;
	// Capture divide operands for the result check
	always_ff @(posedge clk_in) begin
		if (div_start_in && !div_busy_out) begin
			chk_dd <= dividend_even_in;
			chk_dv <= divisor_in;
			chk_plain <= !div_signed_in && !div_long_in;
		end
	end
	wire op_go = op_valid_in;
	property p_add_word;
		op_go && op_code_in == OP_ADD && !byte_mode_in |=> result_out == $past(op_a) + $past(op_b);
	endproperty
	a_add_word: assert property (p_add_word) else $error("word add result wrong");
	property p_and_word;
		op_go && op_code_in == OP_AND && !byte_mode_in |=> result_out == ($past(op_a) & $past(op_b));
	endproperty
	a_and_word: assert property (p_and_word) else $error("and result wrong");
	property p_sub_borrow;
		op_go && is_sub && !byte_mode_in |=> status_word_out[ST_C] == ($past(op_a) >= $past(op_b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");
	property p_add_ov;
		op_go && op_code_in == OP_ADD && !byte_mode_in && op_a[15] == op_b[15]
			|=> status_word_out[ST_OV] == (result_out[15] != $past(op_a[15]));
	endproperty
	a_add_ov: assert property (p_add_ov) else $error("overflow flag wrong");
	property p_byte_zero;
		op_go && byte_mode_in && !is_mul |=> status_word_out[ST_Z] == (result_out[7:0] == 8'h00)
			&& status_word_out[ST_N] == result_out[7];
	endproperty
	a_byte_zero: assert property (p_byte_zero) else $error("byte zero or negative flag wrong");
	property p_mul_ss;
		op_go && op_code_in == OP_MUL_SS |=>
			$signed({result_hi_out, result_out}) == $signed($past(op_a)) * $signed($past(op_b));
	endproperty
	a_mul_ss: assert property (p_mul_ss) else $error("signed product wrong");
	property p_mul_ulit;
		op_go && op_code_in == OP_MUL_ULIT |=>
			{result_hi_out, result_out} == 32'($past(op_a)) * 32'($past(literal_in));
	endproperty
	a_mul_ulit: assert property (p_mul_ulit) else $error("literal product wrong");
	property p_mul_byte;
		op_go && op_code_in == OP_MUL_BYTE |=> result_out == 16'($past(op_a[7:0])) * 16'($past(op_b[7:0]));
	endproperty
	a_mul_byte: assert property (p_mul_byte) else $error("byte product wrong");
	property p_div_time;
		div_start_in && !div_busy_out |=> div_busy_out [*8] ##10 div_done_out;
	endproperty
	a_div_time: assert property (p_div_time) else $error("divide latency wrong");
	property p_div_uu;
		div_done_out && chk_plain && chk_dv != 16'h0000 |->
			32'(quotient_reg_out) * 32'(chk_dv) + 32'(remainder_reg_out) == 32'(chk_dd)
			&& remainder_reg_out < chk_dv;
	endproperty
	a_div_uu: assert property (p_div_uu) else $error("unsigned divide result wrong");
	c_sub: cover property (op_go && is_sub && byte_mode_in);
	c_mul_us: cover property (op_go && op_code_in == OP_MUL_US);
	c_div_long: cover property (div_start_in && div_long_in && div_signed_in ##18 div_done_out);
endmodule // cam_alu_mul_div

`default_nettype wire

// >>> bench/cam_far_model.sv
// Far-side model: working register file, data memory and result write-back
`timescale 1ns/1ps
`default_nettype none
module cam_far_model
	import cam_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Operand and destination selection
	input wire logic [3:0] a_idx_in,
	input wire logic [3:0] b_idx_in,
	input wire logic [3:0] dst_idx_in,
	input wire logic [3:0] pair_idx_in,
	input wire logic [3:0] dvs_idx_in,
	// Results coming back
	input wire logic result_valid_in,
	input wire logic result_to_mem_in,
	input wire logic [CAM_W-1:0] result_in,
	input wire logic div_done_in,
	input wire logic [CAM_W-1:0] quotient_in,
	input wire logic [CAM_W-1:0] remainder_in,
	// Operands
	output logic [CAM_W-1:0] a_file_out,
	output logic [CAM_W-1:0] a_mem_out,
	output logic [CAM_W-1:0] b_file_out,
	output logic [CAM_W-1:0] b_mem_out,
	output logic [CAM_W-1:0] dividend_even_out,
	output logic [CAM_W-1:0] dividend_odd_out,
	output logic [CAM_W-1:0] divisor_out
);
	logic [CAM_W-1:0] regs [16];
	logic [CAM_W-1:0] mem [16];
	// Operand steering from both stores
	assign a_file_out = regs[a_idx_in];
	assign a_mem_out = mem[a_idx_in];
	assign b_file_out = regs[b_idx_in];
	assign b_mem_out = mem[b_idx_in];
	// Pair forced even-aligned so an odd index still picks the right halves
	assign dividend_even_out = regs[{pair_idx_in[3:1], 1'b0}];
	assign dividend_odd_out = regs[{pair_idx_in[3:1], 1'b1}];
	assign divisor_out = regs[dvs_idx_in];
	// Write-back; divide results always land in registers 0 and 1
	always @(posedge clk_in) begin
		if (result_valid_in && result_to_mem_in) mem[dst_idx_in] <= result_in;
		if (result_valid_in && !result_to_mem_in) regs[dst_idx_in] <= result_in;
		if (div_done_in) regs[0] <= quotient_in;
		if (div_done_in) regs[1] <= remainder_in;
	end
endmodule // cam_far_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the arithmetic, multiply and divide unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cam_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic op_valid_in = 1'b0, byte_mode_in = 1'b0, a_from_mem_in = 1'b0, b_from_mem_in = 1'b0, dest_mem_in = 1'b0;
	logic div_start_in = 1'b0, div_signed_in = 1'b0, div_long_in = 1'b0;
	cam_op_e op_code_in = OP_ADD;
	logic [4:0] literal_in = 5'h00;
	logic [15:0] a_file, a_mem, b_file, b_mem, dv_even, dv_odd, dv_sor, result, result_hi, quot, rem;
	logic result_valid, result_to_mem, div_busy, div_done;
	logic [4:0] status;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	// ----------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out();
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (exp !== got) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	cam_alu_mul_div uut (.clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
		.byte_mode_in(byte_mode_in), .literal_in(literal_in), .a_from_mem_in(a_from_mem_in),
		.b_from_mem_in(b_from_mem_in), .a_file_in(a_file), .a_mem_in(a_mem), .b_file_in(b_file), .b_mem_in(b_mem),
		.dest_mem_in(dest_mem_in), .div_start_in(div_start_in), .div_signed_in(div_signed_in),
		.div_long_in(div_long_in), .dividend_even_in(dv_even), .dividend_odd_in(dv_odd), .divisor_in(dv_sor),
		.result_valid_out(result_valid), .result_to_mem_out(result_to_mem), .result_out(result),
		.result_hi_out(result_hi), .status_word_out(status), .div_busy_out(div_busy), .div_done_out(div_done),
		.quotient_reg_out(quot), .remainder_reg_out(rem));
	cam_far_model far (.clk_in(clk_in), .a_idx_in(4'h2), .b_idx_in(4'h3), .dst_idx_in(4'h6), .pair_idx_in(4'h5),
		.dvs_idx_in(4'h7), .result_valid_in(result_valid), .result_to_mem_in(result_to_mem), .result_in(result),
		.div_done_in(div_done), .quotient_in(quot), .remainder_in(rem), .a_file_out(a_file), .a_mem_out(a_mem),
		.b_file_out(b_file), .b_mem_out(b_mem), .dividend_even_out(dv_even), .dividend_odd_out(dv_odd),
		.divisor_out(dv_sor));
	// ----------------------------------------
	// Scenario tasks
	// ----------------------------------------
	// Unused source holds the inverse so a wrong select shows up
	task automatic run_op(cam_op_e op, logic bm, logic src, logic [15:0] a, logic [15:0] b, logic [4:0] lit,
		logic [31:0] exp, logic [4:0] st);
		@(negedge clk_in);
		far.regs[2] = src ? ~a : a;
		far.mem[2] = src ? a : ~a;
		far.regs[3] = src ? b : ~b;
		far.mem[3] = src ? ~b : b;
		op_code_in = op;
		byte_mode_in = bm;
		literal_in = lit;
		a_from_mem_in = src;
		b_from_mem_in = !src;
		dest_mem_in = src;
		op_valid_in = 1'b1;
		@(negedge clk_in);
		op_valid_in = 1'b0;
		chk("result_valid", 1, result_valid);
		chk("result", exp, {result_hi, result});
		chk("status_word", st, status);
		chk("result_to_mem", src, result_to_mem);
	endtask
	// A second start mid-run must be ignored, or done would slip
	task automatic run_div(logic sg, logic lg, logic [15:0] ev, logic [15:0] od, logic [15:0] dv,
		logic [15:0] q, logic [15:0] r);
		@(negedge clk_in);
		far.regs[4] = ev;
		far.regs[5] = od;
		far.regs[7] = dv;
		div_signed_in = sg;
		div_long_in = lg;
		div_start_in = 1'b1;
		for (int n = 1; n < 18; n++) begin
			@(negedge clk_in);
			div_start_in = (n == 5);
			chk("div_busy", 1, div_busy);
			chk("div_done", 0, div_done);
		end
		@(negedge clk_in);
		chk("div_done", 1, div_done);
		chk("div_busy", 0, div_busy);
		chk("quotient_reg", q, quot);
		chk("remainder_reg", r, rem);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(negedge clk_in);
		reset_in = 1'b0;
		chk("reset_status", 0, status);
		chk("reset_result", 0, {result_hi, result});
		chk("reset_flags", 0, {result_valid, result_to_mem, div_busy, div_done});
		chk("reset_div_regs", 0, {quot, rem});
		run_op(OP_ADD, 0, 0, 16'h7FFF, 16'h0001, 5'h00, 32'h00008000, 5'h1C);
		run_op(OP_SUB, 0, 1, 16'h0005, 16'h0005, 5'h00, 32'h00000000, 5'h13);
		run_op(OP_SUB, 0, 0, 16'h0000, 16'h0001, 5'h00, 32'h0000FFFF, 5'h04);
		run_op(OP_ADD, 1, 1, 16'h12FF, 16'h0001, 5'h00, 32'h00001200, 5'h13);
		run_op(OP_AND, 0, 0, 16'hF0F0, 16'h0FF0, 5'h00, 32'h000000F0, 5'h11);
		run_op(OP_XOR, 0, 1, 16'h8000, 16'h0000, 5'h00, 32'h00008000, 5'h15);
		run_op(OP_IOR, 1, 0, 16'hAB00, 16'h0000, 5'h00, 32'h0000AB00, 5'h13);
		run_op(OP_SHL, 0, 1, 16'h8001, 16'h0000, 5'h00, 32'h00000002, 5'h11);
		run_op(OP_LSR, 0, 0, 16'h0001, 16'h0000, 5'h00, 32'h00000000, 5'h13);
		run_op(OP_ASR, 0, 1, 16'h8002, 16'h0000, 5'h00, 32'h0000C001, 5'h14);
		run_op(OP_MUL_SS, 0, 0, 16'hFFFF, 16'h0002, 5'h00, 32'hFFFFFFFE, 5'h14);
		run_op(OP_MUL_UU, 0, 1, 16'hFFFF, 16'h0002, 5'h00, 32'h0001FFFE, 5'h14);
		run_op(OP_MUL_SU, 0, 0, 16'h0002, 16'hFFFF, 5'h00, 32'h0001FFFE, 5'h14);
		run_op(OP_MUL_US, 0, 1, 16'h0002, 16'hFFFF, 5'h00, 32'hFFFFFFFE, 5'h14);
		run_op(OP_MUL_US, 0, 0, 16'hFFFF, 16'h0002, 5'h00, 32'h0001FFFE, 5'h14);
		run_op(OP_MUL_SLIT, 0, 1, 16'hFFFE, 16'h0000, 5'h1F, 32'hFFFFFFC2, 5'h14);
		run_op(OP_MUL_ULIT, 0, 0, 16'hFFFE, 16'h0000, 5'h1F, 32'h001EFFC2, 5'h14);
		run_op(OP_MUL_BYTE, 1, 1, 16'h12FF, 16'h34FE, 5'h00, 32'h0000FD02, 5'h14);
		// Byte subtract: carry says no borrow while the nibble borrows
		run_op(OP_SUB, 1, 0, 16'h5610, 16'h0001, 5'h00, 32'h0000560F, 5'h01);
		run_op(OP_ASR, 1, 1, 16'h3481, 16'h0000, 5'h00, 32'h000034C0, 5'h05);
		// Valid pulse still stands until the next edge, so let it pass
		@(negedge clk_in);
		chk("result_valid", 0, result_valid);
		run_div(0, 0, 16'h0064, 16'h0000, 16'h0007, 16'h000E, 16'h0002);
		run_div(1, 0, 16'hFF9C, 16'h0000, 16'h0007, 16'hFFF2, 16'hFFFE);
		run_div(0, 1, 16'h0000, 16'h0001, 16'h0002, 16'h8000, 16'h0000);
		run_div(1, 1, 16'h0000, 16'hFFFF, 16'hFFFD, 16'h5555, 16'hFFFF);
		run_div(1, 0, 16'h0007, 16'h0000, 16'hFFFE, 16'hFFFD, 16'h0001);
		close_out();
	end
endmodule // testbench
`default_nettype wire
